// [core/cald_pkg.sv]
package cald_pkg;
	localparam logic [7:0] OP_ADD_IMM = 8'h24;
	localparam logic [7:0] OP_ADD_DIR = 8'h25;
	localparam logic [7:0] OP_ADD_CY_IMM = 8'h34;
	localparam logic [7:0] OP_ADD_CY_DIR = 8'h35;
	localparam logic [7:0] OP_SUB_BR_IMM = 8'h94;
	localparam logic [7:0] OP_SUB_BR_DIR = 8'h95;
	localparam logic [7:0] OP_AND_IMM = 8'h54;
	localparam logic [7:0] OP_AND_DIR = 8'h55;
	localparam logic [7:0] OP_AND_DA = 8'h52;
	localparam logic [7:0] OP_AND_DI = 8'h53;
	localparam logic [7:0] OP_OR_IMM = 8'h44;
	localparam logic [7:0] OP_OR_DIR = 8'h45;
	localparam logic [7:0] OP_OR_DA = 8'h42;
	localparam logic [7:0] OP_OR_DI = 8'h43;
	localparam logic [7:0] OP_XOR_IMM = 8'h64;
	localparam logic [7:0] OP_XOR_DIR = 8'h65;
	localparam logic [7:0] OP_XOR_DA = 8'h62;
	localparam logic [7:0] OP_XOR_DI = 8'h63;
	localparam logic [7:0] OP_ROT_L = 8'h23;
	localparam logic [7:0] OP_ROT_LC = 8'h33;
	localparam logic [7:0] OP_ROT_R = 8'h03;
	localparam logic [7:0] OP_ROT_RC = 8'h13;
	localparam logic [4:0] GRP_ADD_REG = 5'h05;
	localparam logic [4:0] GRP_ADD_CY_REG = 5'h07;
	localparam logic [4:0] GRP_SUB_BR_REG = 5'h13;
	localparam logic [4:0] GRP_AND_REG = 5'h0b;
	localparam logic [4:0] GRP_OR_REG = 5'h09;
	localparam logic [4:0] GRP_XOR_REG = 5'h0d;
	localparam logic [6:0] GRP_ADD_IND = 7'h13;
	localparam logic [6:0] GRP_ADD_CY_IND = 7'h1b;
	localparam logic [6:0] GRP_SUB_BR_IND = 7'h4b;
	localparam logic [6:0] GRP_AND_IND = 7'h2b;
	localparam logic [6:0] GRP_OR_IND = 7'h23;
	localparam logic [6:0] GRP_XOR_IND = 7'h33;
	localparam int ACC_ADDR = 8'he0;
	localparam logic [7:0] ACC_DIR_ADDR = 8'he0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] RESET_BANK = 2'h0;
	localparam logic [7:0] NOP_OP = 8'h00;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	localparam int CLK_PER_CYCLE = 1;
	localparam logic [1:0] CLK_PER_CYCLE_W = 2'(CLK_PER_CYCLE);
	localparam int ERAM_DEPTH = 256;
	localparam int ERAM_AW = 8;
	typedef enum logic [3:0] {
		ALU_NONE = 4'h0,
		ALU_ADD = 4'h1,
		ALU_ADD_CY = 4'h2,
		ALU_SUB_BR = 4'h3,
		ALU_AND = 4'h4,
		ALU_OR = 4'h5,
		ALU_XOR = 4'h6,
		ALU_ROT_L = 4'h7,
		ALU_ROT_LC = 4'h8,
		ALU_ROT_R = 4'h9,
		ALU_ROT_RC = 4'ha
	} cald_alu_t;
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_REG = 3'h1,
		SRC_DIR = 3'h2,
		SRC_IND = 3'h3,
		SRC_IMM = 3'h4,
		SRC_ACC = 3'h5
	} cald_src_t;
	typedef struct packed {
		cald_alu_t alu;
		cald_src_t src;
		logic to_direct;
		logic [1:0] len;
		logic legal;
	} cald_dec_t;
	typedef struct packed {
		logic cy;
		logic ac;
		logic ov;
		logic p;
	} cald_flags_t;
	typedef enum logic [1:0] {
		ST_FETCH = 2'b00,
		ST_BYTE2 = 2'b01,
		ST_BYTE3 = 2'b10,
		ST_EXEC = 2'b11
	} cald_state_t;
endpackage : cald_pkg

// [core/cald_ram.sv]
`timescale 1ns/1ps
// Internal data memory; read data come out of a register, so reads take one cycle.
module cald_ram (
	input wire logic clk,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:cald_pkg::ERAM_DEPTH-1];
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule : cald_ram

// [core/cald_core.sv]
`timescale 1ns/1ps
// Executes the arithmetic and logical groups. Code bytes arrive on a simple fetch port.
// Each instruction cycle is one clock, so a byte is taken per clock and execution follows.
module cald_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] code_byte,
	input wire logic [1:0] bank_sel,
	output logic fetch_req_ff,
	output logic [7:0] acc_ff,
	output logic [3:0] flags_ff,
	output logic illegal_ff,
	output logic done_ff,
	output logic [7:0] dir_wr_addr_ff,
	output logic [7:0] dir_wr_data_ff,
	output logic dir_wr_ff
);
	cald_pkg::cald_state_t state_ff;
	cald_pkg::cald_dec_t dec_ff;
	cald_pkg::cald_dec_t nxt_dec;
	logic [7:0] op_ff;
	logic [7:0] b2_ff;
	logic [7:0] b3_ff;
	logic [1:0] cnt_ff;
	logic [7:0] raddr;
	logic [7:0] rdata;
	logic ind_phase_ff;
	logic ram_we;
	logic [7:0] ram_waddr;
	logic [7:0] ram_wdata;
	logic [7:0] opnd;
	logic [7:0] res;
	cald_pkg::cald_flags_t fl;
	cald_pkg::cald_flags_t nxt_fl;
	logic [8:0] s9;
	logic [4:0] s5;
	logic [7:0] s8x;
	logic cin;

	// Decoder: class and length from the first byte.
	always_comb begin
		nxt_dec = '{alu: cald_pkg::ALU_NONE, src: cald_pkg::SRC_NONE, to_direct: 1'b0,
			len: cald_pkg::LEN_ONE, legal: 1'b1};
		case (code_byte[7:3])
			cald_pkg::GRP_ADD_REG: nxt_dec.alu = cald_pkg::ALU_ADD;
			cald_pkg::GRP_ADD_CY_REG: nxt_dec.alu = cald_pkg::ALU_ADD_CY;
			cald_pkg::GRP_SUB_BR_REG: nxt_dec.alu = cald_pkg::ALU_SUB_BR;
			cald_pkg::GRP_AND_REG: nxt_dec.alu = cald_pkg::ALU_AND;
			cald_pkg::GRP_OR_REG: nxt_dec.alu = cald_pkg::ALU_OR;
			cald_pkg::GRP_XOR_REG: nxt_dec.alu = cald_pkg::ALU_XOR;
			default: nxt_dec.alu = cald_pkg::ALU_NONE;
		endcase
		if (nxt_dec.alu != cald_pkg::ALU_NONE) begin
			nxt_dec.src = cald_pkg::SRC_REG;
		end
		case (code_byte[7:1])
			cald_pkg::GRP_ADD_IND: nxt_dec.alu = cald_pkg::ALU_ADD;
			cald_pkg::GRP_ADD_CY_IND: nxt_dec.alu = cald_pkg::ALU_ADD_CY;
			cald_pkg::GRP_SUB_BR_IND: nxt_dec.alu = cald_pkg::ALU_SUB_BR;
			cald_pkg::GRP_AND_IND: nxt_dec.alu = cald_pkg::ALU_AND;
			cald_pkg::GRP_OR_IND: nxt_dec.alu = cald_pkg::ALU_OR;
			cald_pkg::GRP_XOR_IND: nxt_dec.alu = cald_pkg::ALU_XOR;
			default: nxt_dec.alu = nxt_dec.alu;
		endcase
		// Only the pointer groups can have set a class while the source is still open.
		if (nxt_dec.src == cald_pkg::SRC_NONE && nxt_dec.alu != cald_pkg::ALU_NONE) begin
			nxt_dec.src = cald_pkg::SRC_IND;
		end
		case (code_byte)
			cald_pkg::OP_ADD_DIR, cald_pkg::OP_ADD_CY_DIR, cald_pkg::OP_SUB_BR_DIR, cald_pkg::OP_AND_DIR,
			cald_pkg::OP_OR_DIR, cald_pkg::OP_XOR_DIR: begin
				nxt_dec.src = cald_pkg::SRC_DIR;
				nxt_dec.len = cald_pkg::LEN_TWO;
			end
			cald_pkg::OP_ADD_IMM, cald_pkg::OP_ADD_CY_IMM, cald_pkg::OP_SUB_BR_IMM, cald_pkg::OP_AND_IMM,
			cald_pkg::OP_OR_IMM, cald_pkg::OP_XOR_IMM: begin
				nxt_dec.src = cald_pkg::SRC_IMM;
				nxt_dec.len = cald_pkg::LEN_TWO;
			end
			cald_pkg::OP_AND_DA, cald_pkg::OP_OR_DA, cald_pkg::OP_XOR_DA: begin
				nxt_dec.src = cald_pkg::SRC_ACC;
				nxt_dec.to_direct = 1'b1;
				nxt_dec.len = cald_pkg::LEN_TWO;
			end
			cald_pkg::OP_AND_DI, cald_pkg::OP_OR_DI, cald_pkg::OP_XOR_DI: begin
				nxt_dec.src = cald_pkg::SRC_IMM;
				nxt_dec.to_direct = 1'b1;
				nxt_dec.len = cald_pkg::LEN_THREE;
			end
			default: nxt_dec.len = nxt_dec.len;
		endcase
		case (code_byte)
			cald_pkg::OP_ADD_DIR, cald_pkg::OP_ADD_IMM: nxt_dec.alu = cald_pkg::ALU_ADD;
			cald_pkg::OP_ADD_CY_DIR, cald_pkg::OP_ADD_CY_IMM: nxt_dec.alu = cald_pkg::ALU_ADD_CY;
			cald_pkg::OP_SUB_BR_DIR, cald_pkg::OP_SUB_BR_IMM: nxt_dec.alu = cald_pkg::ALU_SUB_BR;
			cald_pkg::OP_AND_DIR, cald_pkg::OP_AND_IMM, cald_pkg::OP_AND_DA, cald_pkg::OP_AND_DI:
				nxt_dec.alu = cald_pkg::ALU_AND;
			cald_pkg::OP_OR_DIR, cald_pkg::OP_OR_IMM, cald_pkg::OP_OR_DA, cald_pkg::OP_OR_DI:
				nxt_dec.alu = cald_pkg::ALU_OR;
			cald_pkg::OP_XOR_DIR, cald_pkg::OP_XOR_IMM, cald_pkg::OP_XOR_DA, cald_pkg::OP_XOR_DI:
				nxt_dec.alu = cald_pkg::ALU_XOR;
			cald_pkg::OP_ROT_L: nxt_dec.alu = cald_pkg::ALU_ROT_L;
			cald_pkg::OP_ROT_LC: nxt_dec.alu = cald_pkg::ALU_ROT_LC;
			cald_pkg::OP_ROT_R: nxt_dec.alu = cald_pkg::ALU_ROT_R;
			cald_pkg::OP_ROT_RC: nxt_dec.alu = cald_pkg::ALU_ROT_RC;
			default: nxt_dec.alu = nxt_dec.alu;
		endcase
		nxt_dec.legal = (nxt_dec.alu != cald_pkg::ALU_NONE);
	end

	// Sequencer: one clock per instruction cycle, one cycle per code byte plus an execute cycle, two for pointer forms.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= cald_pkg::ST_FETCH;
			dec_ff <= '0;
			op_ff <= cald_pkg::NOP_OP;
			b2_ff <= cald_pkg::RESET_BYTE;
			b3_ff <= cald_pkg::RESET_BYTE;
			cnt_ff <= 2'h0;
			fetch_req_ff <= 1'b1;
		end else begin
			case (state_ff)
				cald_pkg::ST_FETCH: begin
					op_ff <= code_byte;
					dec_ff <= nxt_dec;
					cnt_ff <= nxt_dec.len - cald_pkg::CLK_PER_CYCLE_W;
					if (nxt_dec.len == cald_pkg::LEN_ONE) begin
						state_ff <= cald_pkg::ST_EXEC;
						fetch_req_ff <= 1'b0;
					end else begin
						state_ff <= cald_pkg::ST_BYTE2;
					end
				end
				cald_pkg::ST_BYTE2: begin
					b2_ff <= code_byte;
					cnt_ff <= cnt_ff - 2'h1;
					state_ff <= (cnt_ff == 2'h1) ? cald_pkg::ST_EXEC : cald_pkg::ST_BYTE3;
					fetch_req_ff <= (cnt_ff != 2'h1);
				end
				cald_pkg::ST_BYTE3: begin
					b3_ff <= code_byte;
					state_ff <= cald_pkg::ST_EXEC;
					fetch_req_ff <= 1'b0;
				end
				cald_pkg::ST_EXEC: begin
					// Pointer forms stay one more clock here while the pointed-to byte is read.
					if (!ind_phase_ff) begin
						state_ff <= cald_pkg::ST_FETCH;
						fetch_req_ff <= 1'b1;
					end
				end
				default: state_ff <= cald_pkg::ST_FETCH;
			endcase
		end
	end

	// Operand address: bank register, pointer, or direct byte.
	always_comb begin
		raddr = cald_pkg::RESET_BYTE;
		if (state_ff == cald_pkg::ST_FETCH) begin
			raddr = {3'h0, bank_sel, code_byte[2:0]};
			if (nxt_dec.src == cald_pkg::SRC_IND) begin
				raddr = {3'h0, bank_sel, 2'h0, code_byte[0]};
			end
		end else if (state_ff == cald_pkg::ST_BYTE2) begin
			raddr = code_byte;
		end else if (state_ff == cald_pkg::ST_BYTE3) begin
			raddr = b2_ff;
		end
	end

	// Indirect operands take a second read through the fetched pointer, which costs one extra clock.
	always_ff @(posedge clk) begin
		if (rst) begin
			ind_phase_ff <= 1'b0;
		end else begin
			ind_phase_ff <= (state_ff == cald_pkg::ST_FETCH) && (nxt_dec.src == cald_pkg::SRC_IND);
		end
	end

	cald_ram u_ram (
		.clk(clk),
		.we(ram_we),
		.waddr(ram_waddr),
		.wdata(ram_wdata),
		.raddr(ind_phase_ff ? rdata : raddr),
		.rdata(rdata)
	);

	// Arithmetic: flags follow the standard carry, auxiliary carry, overflow and parity definitions.
	always_comb begin
		opnd = (dec_ff.src == cald_pkg::SRC_IMM) ? (dec_ff.to_direct ? b3_ff : b2_ff) : rdata;
		if (dec_ff.src == cald_pkg::SRC_ACC) begin
			opnd = acc_ff;
		end
		fl = cald_pkg::cald_flags_t'(flags_ff);
		nxt_fl = fl;
		cin = (dec_ff.alu == cald_pkg::ALU_ADD_CY || dec_ff.alu == cald_pkg::ALU_SUB_BR) ? fl.cy : 1'b0;
		s8x = (dec_ff.alu == cald_pkg::ALU_SUB_BR) ? ~opnd : opnd;
		s9 = {1'b0, acc_ff} + {1'b0, s8x} + {8'h00, cin ^ (dec_ff.alu == cald_pkg::ALU_SUB_BR)};
		s5 = {1'b0, acc_ff[3:0]} + {1'b0, s8x[3:0]} + {4'h0, cin ^ (dec_ff.alu == cald_pkg::ALU_SUB_BR)};
		res = acc_ff;
		case (dec_ff.alu)
			cald_pkg::ALU_ADD, cald_pkg::ALU_ADD_CY, cald_pkg::ALU_SUB_BR: begin
				res = s9[7:0];
				nxt_fl.cy = s9[8] ^ (dec_ff.alu == cald_pkg::ALU_SUB_BR);
				nxt_fl.ac = s5[4] ^ (dec_ff.alu == cald_pkg::ALU_SUB_BR);
				nxt_fl.ov = (acc_ff[7] == s8x[7]) && (res[7] != acc_ff[7]);
			end
			cald_pkg::ALU_AND: res = (dec_ff.to_direct ? rdata : acc_ff) & opnd;
			cald_pkg::ALU_OR: res = (dec_ff.to_direct ? rdata : acc_ff) | opnd;
			cald_pkg::ALU_XOR: res = (dec_ff.to_direct ? rdata : acc_ff) ^ opnd;
			cald_pkg::ALU_ROT_L: res = {acc_ff[6:0], acc_ff[7]};
			cald_pkg::ALU_ROT_LC: begin
				res = {acc_ff[6:0], fl.cy};
				nxt_fl.cy = acc_ff[7];
			end
			cald_pkg::ALU_ROT_R: res = {acc_ff[0], acc_ff[7:1]};
			cald_pkg::ALU_ROT_RC: begin
				res = {fl.cy, acc_ff[7:1]};
				nxt_fl.cy = acc_ff[0];
			end
			default: res = acc_ff;
		endcase
		ram_we = (state_ff == cald_pkg::ST_EXEC) && !ind_phase_ff && dec_ff.to_direct && dec_ff.legal;
		ram_waddr = b2_ff;
		ram_wdata = res;
	end

	// Direct and pointer reads always land in the clock before write-back, which waits while ind_phase_ff is high.
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_ff <= cald_pkg::RESET_BYTE;
			flags_ff <= 4'h0;
			illegal_ff <= 1'b0;
			done_ff <= 1'b0;
			dir_wr_ff <= 1'b0;
			dir_wr_addr_ff <= cald_pkg::RESET_BYTE;
			dir_wr_data_ff <= cald_pkg::RESET_BYTE;
		end else begin
			done_ff <= (state_ff == cald_pkg::ST_EXEC) && !ind_phase_ff;
			illegal_ff <= (state_ff == cald_pkg::ST_EXEC) && !ind_phase_ff && !dec_ff.legal;
			dir_wr_ff <= ram_we;
			dir_wr_addr_ff <= ram_waddr;
			dir_wr_data_ff <= ram_wdata;
			if (state_ff == cald_pkg::ST_EXEC && !ind_phase_ff && dec_ff.legal) begin
				if (!dec_ff.to_direct) begin
					acc_ff <= res;
				end
				flags_ff <= {nxt_fl.cy, nxt_fl.ac, nxt_fl.ov, ^(dec_ff.to_direct ? acc_ff : res)};
			end
		end
	end
endmodule : cald_core

// [verification/cald_core_monitor.sv]
`timescale 1ns/1ps
module cald_core_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] code_byte,
	input wire logic [1:0] bank_sel,
	input wire logic fetch_req_ff,
	input wire logic [7:0] acc_ff,
	input wire logic [3:0] flags_ff,
	input wire logic illegal_ff,
	input wire logic done_ff,
	input wire logic [7:0] dir_wr_addr_ff,
	input wire logic [7:0] dir_wr_data_ff,
	input wire logic dir_wr_ff
);
	logic boot_ff;
	logic opc;
	// An opcode is taken in the first cycle after reset or in a completion cycle.
	always_ff @(posedge clk) begin
		boot_ff <= rst;
	end
	assign opc = fetch_req_ff && (done_ff || boot_ff);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_exec_then_done: assert property (!fetch_req_ff |-> ##[1:2] (done_ff && fetch_req_ff))
		else $error("Execute cycle not followed by completion");
	chk_done_single: assert property (done_ff |=> !done_ff)
		else $error("Completion pulse longer than one cycle");
	chk_fetch_bound: assert property (fetch_req_ff [*3] |=> !fetch_req_ff)
		else $error("More than three code bytes taken in a row");
	chk_illegal_at_done: assert property (illegal_ff |-> done_ff)
		else $error("Illegal pulse outside completion");
	chk_wr_at_done: assert property (dir_wr_ff |-> done_ff)
		else $error("Direct write outside completion");
	chk_acc_hold: assert property (fetch_req_ff |=> $stable(acc_ff))
		else $error("Accumulator changed outside execute");
	chk_rotate_left: assert property (opc && code_byte == cald_pkg::OP_ROT_L |->
		##2 acc_ff == {$past(acc_ff[6:0], 2), $past(acc_ff[7], 2)})
		else $error("Left rotation result wrong");
	chk_rotate_right: assert property (opc && code_byte == cald_pkg::OP_ROT_R |->
		##2 acc_ff == {$past(acc_ff[0], 2), $past(acc_ff[7:1], 2)})
		else $error("Right rotation result wrong");
	chk_xor_imm: assert property (opc && code_byte == cald_pkg::OP_XOR_IMM |->
		##3 acc_ff == ($past(acc_ff, 3) ^ $past(code_byte, 2)))
		else $error("Immediate xor result wrong");
endmodule : cald_core_monitor

bind cald_core cald_core_monitor cald_core_monitor_inst (.clk(clk), .rst(rst), .code_byte(code_byte),
	.bank_sel(bank_sel), .fetch_req_ff(fetch_req_ff), .acc_ff(acc_ff), .flags_ff(flags_ff),
	.illegal_ff(illegal_ff), .done_ff(done_ff), .dir_wr_addr_ff(dir_wr_addr_ff),
	.dir_wr_data_ff(dir_wr_data_ff), .dir_wr_ff(dir_wr_ff));

// [verification/cald_core_tb.sv]
`timescale 1ns/1ps
module cald_core_tb;
	logic clk, rst, fetch_req_ff, illegal_ff, done_ff, dir_wr_ff;
	logic [7:0] code_byte, acc_ff, dir_wr_addr_ff, dir_wr_data_ff, m_acc, e_wa, e_wd;
	logic [1:0] bank_sel;
	logic [3:0] flags_ff;
	logic [7:0] mem [0:127];
	logic [3:0] grp [6] = '{4'h2, 4'h3, 4'h9, 4'h5, 4'h4, 4'h6};
	logic [15:0] cor [12] = '{16'h5400, 16'h44ff, 16'h2401, 16'h3400, 16'h9401, 16'h0300,
		16'h1300, 16'h2300, 16'h3300, 16'h0800, 16'h947f, 16'h2480};
	logic m_cy, m_ac, m_ov, pend, e_ill, e_wr;
	logic [31:0] lfsr = 32'h67af_ed0a;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	cald_core cald_core_inst (.clk(clk), .rst(rst), .code_byte(code_byte), .bank_sel(bank_sel),
		.fetch_req_ff(fetch_req_ff), .acc_ff(acc_ff), .flags_ff(flags_ff), .illegal_ff(illegal_ff),
		.done_ff(done_ff), .dir_wr_addr_ff(dir_wr_addr_ff), .dir_wr_data_ff(dir_wr_data_ff),
		.dir_wr_ff(dir_wr_ff));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic close_out();
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			close_out();
		end
	end
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	function automatic logic [7:0] rnd();
		repeat (8) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction : rnd
	function automatic void model(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
		logic [7:0] s, d;
		logic [8:0] r;
		logic [4:0] h;
		logic c;
		e_wr = 1'b0;
		e_ill = 1'b0;
		s = op[3] ? mem[{bank_sel, op[2:0]}] : op[1] ? mem[mem[{bank_sel, 2'b00, op[0]}][6:0]]
			: op[0] ? mem[b2[6:0]] : b2;
		c = op[4] & m_cy;
		if (op[3:0] == 4'h3 && op[7:6] == 2'b00) begin
			c = op[5] ? m_acc[7] : m_acc[0];
			d = op[5] ? {m_acc[6:0], op[4] ? m_cy : m_acc[7]} : {op[4] ? m_cy : m_acc[0], m_acc[7:1]};
			if (op[4])
				m_cy = c;
			m_acc = d;
		end else if (op[3:1] == 3'b001) begin
			s = op[0] ? b3 : m_acc;
			d = mem[b2[6:0]];
			d = op[5] ? d ^ s : op[4] ? d & s : d | s;
			mem[b2[6:0]] = d;
			{e_wr, e_wa, e_wd} = {1'b1, b2, d};
		end else case (op[7:4])
			4'h2, 4'h3: begin
				r = {1'b0, m_acc} + {1'b0, s} + {8'h00, c};
				h = {1'b0, m_acc[3:0]} + {1'b0, s[3:0]} + {4'h0, c};
				m_ov = (m_acc[7] == s[7]) && (r[7] != m_acc[7]);
				{m_cy, m_ac, m_acc} = {r[8], h[4], r[7:0]};
			end
			4'h9: begin
				r = {1'b0, m_acc} - {1'b0, s} - {8'h00, m_cy};
				h = {1'b0, m_acc[3:0]} - {1'b0, s[3:0]} - {4'h0, m_cy};
				m_ov = (m_acc[7] != s[7]) && (r[7] != m_acc[7]);
				{m_cy, m_ac, m_acc} = {r[8], h[4], r[7:0]};
			end
			4'h5: m_acc = m_acc & s;
			4'h4: m_acc = m_acc | s;
			4'h6: m_acc = m_acc ^ s;
			default: e_ill = 1'b1;
		endcase
	endfunction : model
	// Results of one instruction are checked while the next opcode is taken, so runs stay back to back.
	task automatic exec(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
		logic [7:0] by [3];
		int n;
		by = '{op, b2, b3};
		n = (op[3:0] == 4'h3 && op[7:6] != 2'b00) ? 3 : (op[3:1] == 3'b010 || op[3:0] == 4'h2) ? 2 : 1;
		for (int i = 0; i < n; i++) begin
			code_byte <= by[i];
			if (i == 0)
				bank_sel <= lfsr[9:8];
			@(posedge clk);
			cmp("fetch_req", 8'h01, {7'h00, fetch_req_ff});
			if (i == 0 && pend) begin
				cmp("done", 8'h01, {7'h00, done_ff});
				cmp("acc", m_acc, acc_ff);
				cmp("flags", {4'h0, m_cy, m_ac, m_ov, ^m_acc}, {4'h0, flags_ff});
				cmp("illegal", {7'h00, e_ill}, {7'h00, illegal_ff});
				cmp("dir_wr", {7'h00, e_wr}, {7'h00, dir_wr_ff});
				if (e_wr)
					cmp("dir_wr_addr", e_wa, dir_wr_addr_ff);
				if (e_wr)
					cmp("dir_wr_data", e_wd, dir_wr_data_ff);
			end
		end
		model(op, b2, b3);
		pend = 1'b1;
		@(posedge clk);
		cmp("exec_idle", 8'h00, {7'h00, fetch_req_ff});
		if (op[3:1] == 3'b011 && !e_ill) begin
			@(posedge clk);
			cmp("ind_idle", 8'h00, {7'h00, fetch_req_ff});
		end
	endtask : exec
	task automatic rand_run(input int k);
		logic [7:0] r, s, op, b2;
		repeat (k) begin
			r = rnd();
			s = rnd();
			op = {grp[r[2:0] % 6], r[7] ? r[7:4] : {2'b01, r[5:4]}};
			if (s < 8'd50)
				op = {grp[s % 3 + 3], 3'b001, s[0]};
			else if (s < 8'd70)
				op = {2'b00, s[1:0], 4'h3};
			b2 = rnd();
			if (op[3:0] != 4'h4)
				b2 = {1'b0, b2[6:0]};
			if (op[3:1] == 3'b001)
				b2 = {2'b01, b2[5:0]};
			exec(op, b2, rnd());
		end
	endtask : rand_run
	initial begin
		{rst, pend, m_acc, m_cy, m_ac, m_ov} = {1'b1, 12'h000};
		code_byte = 8'h00;
		bank_sel = 2'h0;
		repeat (16) @(posedge clk);
		cmp("reset_fetch", 8'h01, {7'h00, fetch_req_ff});
		rst <= 1'b0;
		for (int a = 0; a < 128; a++) begin
			exec(8'h53, a[7:0], 8'h00);
			exec(8'h43, a[7:0], rnd() & 8'h7f);
		end
		foreach (cor[i])
			exec(cor[i][15:8], cor[i][7:0], 8'h00);
		rand_run(300);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		cmp("reset_acc", 8'h00, acc_ff);
		rst <= 1'b0;
		{pend, m_acc, m_cy, m_ac, m_ov} = 12'h000;
		rand_run(100);
		exec(8'h08, 8'h00, 8'h00);
		close_out();
	end
endmodule : cald_core_tb
